// file: rtl/amp_pin_defs.svh
// constants for the amplifier pin control and protection block
// assumes it is included by the pin control and protection module
`ifndef AMP_PIN_DEFS_SVH
`define AMP_PIN_DEFS_SVH

// number of output stages
`define NUM_STAGES 4

// synchroniser vector layout and reset value
`define SYNC_W 21
`define SYNC_RST 21'h00001
`define SY_PDN 0
`define SY_OUTPUT_TOPOLOGY_STRAP0 1
`define SY_OUTPUT_TOPOLOGY_STRAP1 2
`define SY_AMP_CONFIG_STRAP0 3
`define SY_AMP_CONFIG_STRAP1 4
`define SY_VOLA 5
`define SY_VOLB 6
`define SY_TREF 7
`define SY_TSNS 8
`define SY_TCOM 9
`define SY_OVC 10
`define SY_OVL 14
`define SY_UV 18

// cycles after reset release before straps are captured
`define STRAP_SETTLE 3'h5

// calibration counter width and saturation value
`define CAL_W 16
`define CAL_MAX 16'hFFFF

`endif

// file: rtl/amp_pin_pkg.sv
// types shared by the amplifier pin control block
// assumes the constants header sits beside it
package amp_pin_pkg;
    // operating state of the device
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_INIT = 2'b01,
        ST_BOOT = 2'b10,
        ST_RUN = 2'b11
    } dev_state_t;
    // four configuration modes
    typedef enum logic [1:0] {
        MODE_0 = 2'b00,
        MODE_1 = 2'b01,
        MODE_2 = 2'b10,
        MODE_3 = 2'b11
    } cfg_mode_t;
    // per-stage monitor flags
    typedef struct packed {
        logic [3:0] overcurrent;
        logic [3:0] overload;
    } stage_flags_t;
    // supply undervoltage flags
    typedef struct packed {
        logic hv_rail;
        logic driver_regulator_rail;
        logic pwm_supply_rail;
    } supply_uv_t;
    // volume encoder step pulses
    typedef struct packed {
        logic up;
        logic down;
    } vol_step_t;
endpackage : amp_pin_pkg

// file: rtl/pin_sync3.sv
// three-flop pin synchroniser with agreement filter
// assumes inputs are asynchronous to mclk_i
`timescale 1ns/1ps
module pin_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] level_o
);
    logic [W-1:0] s1_q; // first stage, read by s2 only
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] level_q; // accepted level
    logic [W-1:0] agree;

    // second and third stage must agree before a change counts
    assign agree = ~(s2_q ^ s3_q);

    // ----------------------------------------
    // shift chain and filtered level
    // ----------------------------------------
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_q <= RST;
            s2_q <= RST;
            s3_q <= RST;
            level_q <= RST;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            level_q <= (level_q & ~agree) | (s3_q & agree);
        end
    end

    assign level_o = level_q;
endmodule : pin_sync3

// file: rtl/amp_pin_control_protect.sv
// pin control, pin role switching and stage protection
// assumes pins arrive asynchronous; firmware controls arrive on mclk_i
`timescale 1ns/1ps
`include "amp_pin_defs.svh"
module amp_pin_control_protect (
    input wire logic mclk_i,
    input wire logic rst_i,
    // power-down and straps
    input wire logic output_power_down_n_i,
    input wire logic output_topology_strap0_i,
    input wire logic output_topology_strap1_i,
    // analog monitor flags
    input wire amp_pin_pkg::stage_flags_t stage_flags_i,
    input wire amp_pin_pkg::supply_uv_t supply_uv_i,
    // firmware controls
    input wire logic [3:0] fw_stage_shutdown_i,
    input wire logic [3:0] fw_latch_clear_i,
    input wire logic temp_fault_i,
    input wire logic boot_start_i,
    input wire logic fw_run_i,
    input wire logic supply_sync_level_i,
    input wire logic spi_sck_i,
    input wire logic spi_mosi_i,
    input wire logic spi_miso_i,
    input wire logic temp_drive_i,
    input wire logic temp_drive_en_i,
    // shared pin: config strap 0 / protection status
    input wire logic amp_config_strap0_i,
    output logic amp_config_strap0_o,
    output logic amp_config_strap0_oe_o,
    // shared pin: config strap 1 / supply sync
    input wire logic amp_config_strap1_i,
    output logic supply_sync_out_o,
    output logic supply_sync_out_oe_o,
    // shared pin: spi clock / temperature reference
    input wire logic temp_reference_in_i,
    output logic temp_reference_in_o,
    output logic temp_reference_in_oe_o,
    // shared pin: spi master out / temperature sense
    input wire logic temp_sense_io_i,
    output logic temp_sense_io_o,
    output logic temp_sense_io_oe_o,
    // shared pin: slave select / volume phase a
    input wire logic volume_phase_a_i,
    // shared pin: spi master in / volume phase b
    input wire logic volume_phase_b_i,
    output logic volume_phase_b_o,
    output logic volume_phase_b_oe_o,
    // temperature common timing pin
    input wire logic temp_common_pin_i,
    // stage fault pins, open drain
    output logic [3:0] stage_fault_n_o,
    output logic [3:0] stage_fault_n_oe_o,
    // stage drive and status
    output logic [3:0] pwm_enable_o,
    output logic [3:0] stage_float_o,
    output logic audio_mute_o,
    output logic [3:0] oc_latched_o,
    output amp_pin_pkg::dev_state_t dev_state_o,
    output amp_pin_pkg::cfg_mode_t amp_mode_o,
    output amp_pin_pkg::cfg_mode_t topology_o,
    output logic mode_mismatch_o,
    output logic spi_rx_o,
    output amp_pin_pkg::vol_step_t vol_step_o,
    output logic temp_ref_level_o,
    output logic temp_sense_level_o,
    output logic [15:0] temp_cal_count_o
);
    import amp_pin_pkg::*;

    // ----------------------------------------
    // synchronised pins
    // ----------------------------------------
    logic [`SYNC_W-1:0] pins_raw; // all asynchronous inputs
    logic [`SYNC_W-1:0] pins_s; // filtered levels
    logic pd_s; // power-down requested
    logic uv_any; // any supply low
    logic [3:0] ovc_s; // overcurrent per stage
    logic [3:0] ovl_s; // overload per stage

    assign pins_raw = {supply_uv_i, stage_flags_i.overload, stage_flags_i.overcurrent,
                       temp_common_pin_i, temp_sense_io_i, temp_reference_in_i,
                       volume_phase_b_i, volume_phase_a_i, amp_config_strap1_i,
                       amp_config_strap0_i, output_topology_strap1_i,
                       output_topology_strap0_i, output_power_down_n_i};

    // every pin passes the filter first
    pin_sync3 #(
        .W(`SYNC_W),
        .RST(`SYNC_RST)
    ) u_sync (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .pin_i(pins_raw),
        .level_o(pins_s)
    );

    // low level requests power-down
    assign pd_s = ~pins_s[`SY_PDN];
    // undervoltage on any stage supply
    assign uv_any = |pins_s[`SY_UV +: 3];
    assign ovc_s = pins_s[`SY_OVC +: 4];
    assign ovl_s = pins_s[`SY_OVL +: 4];

    // ----------------------------------------
    // operating state
    // ----------------------------------------
    dev_state_t state_q; // current operating state
    logic [2:0] settle_q; // strap settle counter
    logic settle_done; // straps valid
    logic run; // firmware running
    logic spi_role; // init or boot phase

    assign settle_done = (settle_q == `STRAP_SETTLE);
    assign run = (state_q == ST_RUN);
    assign spi_role = (state_q == ST_INIT) || (state_q == ST_BOOT);

    // counts edges until synchronised straps are valid
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            settle_q <= 3'h0;
        end else if (state_q == ST_RESET && !settle_done) begin
            settle_q <= settle_q + 3'h1;
        end
    end

    // state walk; power-down never resets it
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_RESET;
        end else begin
            case (state_q)
                ST_RESET: begin
                    // leave reset once straps settled
                    if (settle_done) begin
                        state_q <= ST_INIT;
                    end
                end
                ST_INIT: begin
                    if (boot_start_i) begin
                        state_q <= ST_BOOT;
                    end
                end
                ST_BOOT: begin
                    if (fw_run_i) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    // stays until reset
                    state_q <= ST_RUN;
                end
                default: begin
                    state_q <= ST_RESET;
                end
            endcase
        end
    end

    // ----------------------------------------
    // configuration capture
    // ----------------------------------------
    cfg_mode_t cfg_mode_q; // captured amplifier mode
    cfg_mode_t topo; // live topology straps
    logic mismatch_q; // strap pairs disagree

    // topology read live from the filtered pins, not captured
    assign topo = cfg_mode_t'(pins_s[`SY_OUTPUT_TOPOLOGY_STRAP1:`SY_OUTPUT_TOPOLOGY_STRAP0]);

    // capture on leaving reset, hold until next reset
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_mode_q <= MODE_0;
        end else if (state_q == ST_RESET && settle_done) begin
            cfg_mode_q <= cfg_mode_t'(pins_s[`SY_AMP_CONFIG_STRAP1:`SY_AMP_CONFIG_STRAP0]);
        end
    end

    // board must set both pairs alike; flag when not
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            mismatch_q <= 1'b0;
        end else begin
            mismatch_q <= (state_q != ST_RESET) && (topo != cfg_mode_q);
        end
    end

    // ----------------------------------------
    // stage protection
    // ----------------------------------------
    logic [3:0] oc_latch_q; // hardware overcurrent latch
    logic [3:0] fault_q; // fault pin pulled
    logic [3:0] pwm_en_q; // stage drive on
    logic mute_q; // audio outputs off
    logic status_n_q; // summary status, low on fault

    // overcurrent sets; power-down or firmware clears; set wins
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            oc_latch_q <= 4'h0;
        end else begin
            oc_latch_q <= ovc_s | (oc_latch_q & ~({4{pd_s}} | fw_latch_clear_i));
        end
    end

    // per-stage fault pin and drive enable
    for (genvar i = 0; i < `NUM_STAGES; i++) begin : g_stage
        always_ff @(posedge mclk_i or posedge rst_i) begin
            if (rst_i) begin
                fault_q[i] <= 1'b0;
                pwm_en_q[i] <= 1'b0;
            end else begin
                // own flags, plus shared supply and power-down
                fault_q[i] <= pd_s | uv_any | ovc_s[i] | ovl_s[i];
                // drive stops at once on overcurrent, not a cycle after the latch
                pwm_en_q[i] <= run & ~pd_s & ~uv_any & ~oc_latch_q[i]
                               & ~ovc_s[i] & ~fw_stage_shutdown_i[i] & ~temp_fault_i;
            end
        end
        // open drain: only ever pulls low
        assign stage_fault_n_o[i] = 1'b0;
        assign stage_fault_n_oe_o[i] = fault_q[i];
    end

    // audio mute and summary status
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            mute_q <= 1'b1;
            status_n_q <= 1'b1;
        end else begin
            mute_q <= pd_s;
            status_n_q <= ~(pd_s | uv_any | (|ovc_s) | (|ovl_s) | (|oc_latch_q) | temp_fault_i);
        end
    end

    // ----------------------------------------
    // shared pin roles by state
    // ----------------------------------------
    logic spi_master; // slave select high means master

    assign spi_master = pins_s[`SY_VOLA];

    always_comb begin
        // released by default
        amp_config_strap0_o = 1'b0;
        amp_config_strap0_oe_o = 1'b0;
        supply_sync_out_o = 1'b0;
        supply_sync_out_oe_o = 1'b0;
        temp_reference_in_o = 1'b0;
        temp_reference_in_oe_o = 1'b0;
        temp_sense_io_o = 1'b0;
        temp_sense_io_oe_o = 1'b0;
        volume_phase_b_o = 1'b0;
        volume_phase_b_oe_o = 1'b0;
        if (run) begin
            // strap pins become outputs
            amp_config_strap0_o = status_n_q;
            amp_config_strap0_oe_o = 1'b1;
            supply_sync_out_o = supply_sync_level_i;
            supply_sync_out_oe_o = 1'b1;
            // reference is input, sense is firmware i/o
            temp_sense_io_o = temp_drive_i;
            temp_sense_io_oe_o = temp_drive_en_i;
        end else if (spi_role) begin
            // clock out, data direction from slave select
            temp_reference_in_o = spi_sck_i;
            temp_reference_in_oe_o = 1'b1;
            if (spi_master) begin
                temp_sense_io_o = spi_mosi_i;
                temp_sense_io_oe_o = 1'b1;
            end else begin
                volume_phase_b_o = spi_miso_i;
                volume_phase_b_oe_o = 1'b1;
            end
        end
    end

    // received spi data bit
    logic spi_rx_q;
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            spi_rx_q <= 1'b0;
        end else if (spi_role) begin
            spi_rx_q <= spi_master ? pins_s[`SY_VOLB] : pins_s[`SY_TSNS];
        end
    end

    // ----------------------------------------
    // rotary volume encoder
    // ----------------------------------------
    logic [1:0] enc_q; // previous phase a, b
    logic [1:0] enc_now; // current phase a, b
    vol_step_t step_q; // step pulses
    logic one_change; // exactly one phase moved

    assign enc_now = {pins_s[`SY_VOLA], pins_s[`SY_VOLB]};
    assign one_change = ^(enc_now ^ enc_q);

    // direction from old phase a against new phase b
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            enc_q <= 2'b00;
            step_q <= '0;
        end else begin
            enc_q <= enc_now;
            step_q.up <= run & one_change & (enc_q[1] ^ enc_now[0]);
            step_q.down <= run & one_change & ~(enc_q[1] ^ enc_now[0]);
        end
    end

    // ----------------------------------------
    // temperature calibration timer
    // ----------------------------------------
    logic tcom_q; // previous common pin level
    logic tcom_rise; // rising edge seen
    logic [`CAL_W-1:0] cal_cnt_q; // clocks since last edge
    logic [`CAL_W-1:0] cal_q; // last full period

    assign tcom_rise = pins_s[`SY_TCOM] & ~tcom_q;

    // period of the common pin in system clocks
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            tcom_q <= 1'b0;
            cal_cnt_q <= '0;
            cal_q <= '0;
        end else begin
            tcom_q <= pins_s[`SY_TCOM];
            if (!run) begin
                cal_cnt_q <= '0;
            end else if (tcom_rise) begin
                cal_q <= cal_cnt_q;
                cal_cnt_q <= `CAL_W'(1);
            end else if (cal_cnt_q != `CAL_MAX) begin
                cal_cnt_q <= cal_cnt_q + `CAL_W'(1);
            end
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign pwm_enable_o = pwm_en_q;
    assign stage_float_o = ~pwm_en_q;
    assign audio_mute_o = mute_q;
    assign oc_latched_o = oc_latch_q;
    assign dev_state_o = state_q;
    assign amp_mode_o = cfg_mode_q;
    assign topology_o = topo;
    assign mode_mismatch_o = mismatch_q;
    assign spi_rx_o = spi_rx_q;
    assign vol_step_o = step_q;
    assign temp_ref_level_o = pins_s[`SY_TREF];
    assign temp_sense_level_o = pins_s[`SY_TSNS];
    assign temp_cal_count_o = cal_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    // one forward encoder step while running
    sequence s_enc_fwd;
        run && enc_now == 2'b01 && enc_q == 2'b00;
    endsequence
    // reset phase ends into init
    sequence s_leave_reset;
        state_q == ST_RESET ##1 state_q == ST_INIT;
    endsequence

    AST_PD_STOPS: assert property (pd_s |=> pwm_en_q == 4'h0 && mute_q)
        else $error("drive not stopped in power-down");
    AST_PD_FAULTS: assert property (pd_s |=> stage_fault_n_oe_o == 4'hF)
        else $error("power-down did not pull all faults");
    AST_UV_FAULTS: assert property (uv_any |=> &stage_fault_n_oe_o)
        else $error("undervoltage did not pull all faults");
    AST_PD_CLEARS: assert property (pd_s && ovc_s == 4'h0 |=> oc_latch_q == 4'h0)
        else $error("power-down left a latch set");
    AST_PD_HOLDS_STATE: assert property (pd_s && state_q == ST_RUN |=> state_q == ST_RUN)
        else $error("power-down disturbed operating state");
    AST_RUN_PINS: assert property (run |-> amp_config_strap0_oe_o && supply_sync_out_oe_o
                                   && !temp_reference_in_oe_o)
        else $error("run pin roles wrong");
    AST_SPI_MASTER: assert property (spi_role && spi_master |-> temp_sense_io_oe_o
                                     && !volume_phase_b_oe_o && temp_reference_in_oe_o)
        else $error("spi master directions wrong");
    AST_STRAP_CAPTURE: assert property (s_leave_reset |->
                                        cfg_mode_q == $past(pins_s[`SY_AMP_CONFIG_STRAP1:`SY_AMP_CONFIG_STRAP0]))
        else $error("config straps not captured");
    AST_MODE_HELD: assert property (state_q != ST_RESET |=> $stable(cfg_mode_q))
        else $error("captured mode changed");
    AST_VOL_UP: assert property (s_enc_fwd |=> step_q.up && !step_q.down)
        else $error("encoder step missed");

    for (genvar k = 0; k < `NUM_STAGES; k++) begin : g_chk
        AST_OWN_FAULT: assert property (ovl_s[k] |=> fault_q[k])
            else $error("overload did not flag its stage");
        AST_LATCH_SET: assert property (ovc_s[k] |=> oc_latch_q[k] && !pwm_en_q[k])
            else $error("overcurrent latch not set");
        AST_FW_CLEAR: assert property (fw_latch_clear_i[k] && !ovc_s[k] |=> !oc_latch_q[k])
            else $error("firmware clear ignored");
    end
endmodule : amp_pin_control_protect

// file: bench/amp_board_model.sv
// board model: strap pull resistors and open-drain fault lines with pull-ups
// assumes the bench supplies the strapped mode and the design's pin drives
`timescale 1ns/1ps
module amp_board_model (
    input wire logic [1:0] mode_i,
    input wire logic strap0_o_i,
    input wire logic strap0_oe_i,
    input wire logic strap1_o_i,
    input wire logic strap1_oe_i,
    input wire logic [3:0] fault_oe_i,
    output logic [1:0] topo_pin_o,
    output logic strap0_pin_o,
    output logic strap1_pin_o,
    output logic [3:0] fault_line_o
);
    // topology pair strapped to the same mode as the config pair
    assign topo_pin_o = mode_i;
    // released config pins fall back to their pull level
    assign strap0_pin_o = strap0_oe_i ? strap0_o_i : mode_i[0];
    assign strap1_pin_o = strap1_oe_i ? strap1_o_i : mode_i[1];
    // pull-up on each open-drain line
    assign fault_line_o = ~fault_oe_i;
endmodule : amp_board_model

// file: bench/amp_pin_control_protect_bench.sv
// self-checking bench for the pin control and protection block
// assumes the board model beside it; pin changes settle within 6 edges
`timescale 1ns/1ps
module amp_pin_control_protect_bench;
    import amp_pin_pkg::*;
    logic mclk_i, rst_i, pdn_n, tfault, boot, run, sync_lvl;
    stage_flags_t flags;
    supply_uv_t uv;
    logic [3:0] fw_sd, fw_clr, k4, fault_line;
    logic [9:0] misc;
    logic [1:0] mode, topo;
    logic s0_pin, s1_pin, s0_o, s0_oe, sy_o, sy_oe, mute, tr_oe, mm;
    logic [3:0] f_oe, pwm, flt, ocl;
    dev_state_t st;
    cfg_mode_t am, tp;
    logic [3:0] sel_q[$];
    logic [15:0] exp_q[$];
    logic [3:0] s;
    logic [15:0] e;
    int n_fail, check_count;
    string nm[13] = '{"state", "amp_mode", "topology", "pwm", "fault_oe", "oc_latched",
        "float", "mute", "pin_oe", "fault_line", "sync", "mismatch", "status"};
    amp_pin_control_protect dut_u (.mclk_i(mclk_i), .rst_i(rst_i),
        .output_power_down_n_i(pdn_n), .output_topology_strap0_i(topo[0]),
        .output_topology_strap1_i(topo[1]), .stage_flags_i(flags), .supply_uv_i(uv),
        .fw_stage_shutdown_i(fw_sd), .fw_latch_clear_i(fw_clr), .temp_fault_i(tfault),
        .boot_start_i(boot), .fw_run_i(run), .supply_sync_level_i(sync_lvl),
        .spi_sck_i(misc[0]), .spi_mosi_i(misc[1]), .spi_miso_i(misc[2]),
        .temp_drive_i(misc[3]), .temp_drive_en_i(misc[4]),
        .amp_config_strap0_i(s0_pin), .amp_config_strap0_o(s0_o),
        .amp_config_strap0_oe_o(s0_oe), .amp_config_strap1_i(s1_pin),
        .supply_sync_out_o(sy_o), .supply_sync_out_oe_o(sy_oe),
        .temp_reference_in_i(misc[5]), .temp_reference_in_o(), .temp_reference_in_oe_o(tr_oe),
        .temp_sense_io_i(misc[6]), .temp_sense_io_o(), .temp_sense_io_oe_o(),
        .volume_phase_a_i(misc[7]), .volume_phase_b_i(misc[8]), .volume_phase_b_o(),
        .volume_phase_b_oe_o(), .temp_common_pin_i(misc[9]), .stage_fault_n_o(),
        .stage_fault_n_oe_o(f_oe), .pwm_enable_o(pwm), .stage_float_o(flt),
        .audio_mute_o(mute), .oc_latched_o(ocl), .dev_state_o(st), .amp_mode_o(am),
        .topology_o(tp), .mode_mismatch_o(mm), .spi_rx_o(), .vol_step_o(),
        .temp_ref_level_o(), .temp_sense_level_o(), .temp_cal_count_o());
    amp_board_model board_u (.mode_i(mode), .strap0_o_i(s0_o), .strap0_oe_i(s0_oe),
        .strap1_o_i(sy_o), .strap1_oe_i(sy_oe), .fault_oe_i(f_oe), .topo_pin_o(topo),
        .strap0_pin_o(s0_pin), .strap1_pin_o(s1_pin), .fault_line_o(fault_line));
    // ----------------------------------------
    // clock, result picking and comparison
    // ----------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end
    function automatic logic [15:0] obs(input logic [3:0] c);
        case (c)
            0: obs = {14'h0, st};
            1: obs = {14'h0, am};
            2: obs = {14'h0, tp};
            3: obs = {12'h0, pwm};
            4: obs = {12'h0, f_oe};
            5: obs = {12'h0, ocl};
            6: obs = {12'h0, flt};
            7: obs = {15'h0, mute};
            8: obs = {13'h0, tr_oe, s0_oe, sy_oe};
            9: obs = {12'h0, fault_line};
            11: obs = {15'h0, mm};
            12: obs = {15'h0, s0_o};
            default: obs = {15'h0, sy_o};
        endcase
    endfunction : obs
    task automatic check_vec(input logic [3:0] c, input logic [15:0] x, input logic [15:0] y);
        check_count++;
        if (y !== x) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm[c], x, y);
        end
    endtask : check_vec
    task automatic note(input logic [3:0] c, input logic [15:0] x);
        sel_q.push_back(c);
        exp_q.push_back(x);
    endtask : note
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge mclk_i);
            misc <= 10'($urandom);
        end
    endtask : tick
    // monitor checks every queued note, oldest first, once outputs have settled
    always @(negedge mclk_i) begin
        while (exp_q.size() > 0) begin
            s = sel_q.pop_front();
            e = exp_q.pop_front();
            check_vec(s, e, obs(s));
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    // watchdog well beyond the expected run length
    initial begin
        #(25 * 3000);
        n_fail++;
        tally_and_finish();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        mode = 2'($urandom(62503));
        {rst_i, pdn_n, tfault, boot, run, sync_lvl} = 6'b110000;
        {flags, uv, fw_sd, fw_clr, misc} = '0;
        tick(3);
        rst_i <= 1'b0;
        tick(1);
        note(0, 16'h0000);
        tick(6);
        note(0, 16'h0001);
        note(1, {14'h0, mode});
        note(2, {14'h0, mode});
        run <= 1'b1;
        tick(1);
        run <= 1'b0;
        tick(1);
        note(0, 16'h0001);
        note(8, 16'h0004);
        boot <= 1'b1;
        tick(1);
        boot <= 1'b0;
        run <= 1'b1;
        note(0, 16'h0002);
        tick(1);
        run <= 1'b0;
        sync_lvl <= 1'($urandom);
        tick(6);
        note(0, 16'h0003);
        note(8, 16'h0003);
        note(10, {15'h0, sync_lvl});
        note(12, 16'h0001);
        note(11, 16'h0000);
        note(1, {14'h0, mode});
        note(3, 16'h000F);
        for (int k = 0; k < 4; k++) begin
            k4 = 4'h1 << k;
            flags.overcurrent <= k4;
            tick(6);
            note(5, {12'h0, k4});
            note(4, {12'h0, k4});
            note(9, {12'h0, ~k4});
            note(3, {12'h0, ~k4});
            note(12, 16'h0000);
            flags.overcurrent <= 4'h0;
            tick(6);
            note(5, {12'h0, k4});
            fw_clr <= k4;
            tick(1);
            fw_clr <= 4'h0;
            tick(1);
            note(5, 16'h0000);
            flags.overload <= k4;
            tick(6);
            note(4, {12'h0, k4});
            flags.overload <= 4'h0;
            tick(6);
        end
        for (int u = 0; u < 3; u++) begin
            uv <= 3'h1 << u;
            tick(6);
            note(4, 16'h000F);
            uv <= 3'h0;
            tick(6);
        end
        fw_sd <= 4'($urandom);
        tick(2);
        note(3, {12'h0, ~fw_sd});
        fw_sd <= 4'h0;
        tfault <= 1'b1;
        tick(2);
        note(3, 16'h0000);
        note(12, 16'h0000);
        tfault <= 1'b0;
        flags.overcurrent <= 4'($urandom) | 4'h1;
        tick(6);
        flags.overcurrent <= 4'h0;
        pdn_n <= 1'b0;
        tick(6);
        note(3, 16'h0000);
        note(6, 16'h000F);
        note(7, 16'h0001);
        note(4, 16'h000F);
        note(5, 16'h0000);
        note(0, 16'h0003);
        pdn_n <= 1'b1;
        tick(6);
        note(3, 16'h000F);
        note(7, 16'h0000);
        note(1, {14'h0, mode});
        tick(2);
        tally_and_finish();
    end
endmodule : amp_pin_control_protect_bench
